// ==== dp_slave_buffer_exchange.sv ====
module dp_slave_buffer_exchange (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        out_rx_ok_i,
	input  wire logic        in_send_req_i,
	input  wire logic        exch_rx_i,
	input  wire logic        diag_fetched_i,
	input  wire logic        diag_static_i,
	input  wire logic        diag_sending_i,
	input  wire logic        gc_sync_i,
	input  wire logic        gc_unsync_i,
	input  wire logic        gc_freeze_i,
	input  wire logic        gc_unfreeze_i,
	input  wire logic        gc_wipe_i,
	input  wire logic        enter_await_i,
	input  wire logic        drop_master_i,
	input  wire logic        go_cyclic_i,
	input  wire logic        prm_cfg_pending_i,
	output logic             output_received_irq_o,
	output logic             diag_swap_done_o,
	output logic             diag_high_prio_o,
	output logic [1:0]       diag_send_buf_o,
	output logic [1:0]       dout_d_ptr_o,
	output logic [1:0]       din_d_ptr_o,
	output logic             dout_wipe_o,
	output logic             drop_master_o,
	output logic             cyclic_exchange_state_o
);
	dp_buf_pkg::buf_pos_t    out_r, out_nxt, out_bus;
	dp_buf_pkg::buf_pos_t    in_r, in_nxt, in_bus;
	dp_buf_pkg::link_state_t link_r;
	logic        out_new_r, out_new_nxt, n_clr_r, n_clr_nxt, u_clr_r, u_clr_nxt;
	logic        in_new_r, in_new_nxt;
	logic        out_hold_r, in_hold_r, d_held_r;
	logic        sync_en_r, freeze_en_r, kick_r, start_r;
	logic [15:0] reload_r, count_r;
	logic        pend_r, release_r;
	logic [1:0]  host_buf_r, active_r;
	logic        acc, rd, wr;
	logic [5:0]  idx;
	logic        wipe, rx_move, sync_move, take_cmd, take_done;
	logic        send_move, freeze_move, pub_cmd, swap_cmd, swap_now;
	logic        wd_hit, cyc;
	logic [31:0] rdata;

	// D (or U) goes to N; the free buffer, or the unfetched N, refills the source
	function automatic dp_buf_pkg::buf_pos_t push_n(input dp_buf_pkg::buf_pos_t p,
			input logic from_u);
		dp_buf_pkg::buf_pos_t q;
		logic [1:0] refill;
		q = p;
		q.n = from_u ? p.u : p.d;
		refill = (p.f != dp_buf_pkg::PTR_NIL) ? p.f : p.n;
		q.f = (p.f != dp_buf_pkg::PTR_NIL) ? p.n : dp_buf_pkg::PTR_NIL;
		q.u = from_u ? refill : p.u;
		q.d = from_u ? p.d : refill;
		return q;
	endfunction
	// N goes to D (or U); the old one becomes free
	function automatic dp_buf_pkg::buf_pos_t pull_n(input dp_buf_pkg::buf_pos_t p,
			input logic to_u);
		dp_buf_pkg::buf_pos_t q;
		q = p;
		q.n = dp_buf_pkg::PTR_NIL;
		q.f = to_u ? p.u : p.d;
		q.u = to_u ? p.n : p.u;
		q.d = to_u ? p.d : p.n;
		return q;
	endfunction

	function automatic logic [1:0] diag_code(input logic [1:0] b, input logic [1:0] host,
			input logic [1:0] act, input logic rel, input logic sending);
		logic [1:0] c;
		c = dp_buf_pkg::OWN_DEV;
		if (host == b) begin
			c = dp_buf_pkg::OWN_HOST;
		end else if (b == act) begin
			// while a release is pending the wire still carries the old buffer
			c = (sending & ~rel) ? dp_buf_pkg::OWN_SEND : dp_buf_pkg::OWN_DEV;
		end else if (rel) begin
			c = dp_buf_pkg::OWN_SEND;
		end
		return c;
	endfunction
	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign rd  = acc & ~wb_we_i;
	assign wr  = acc & wb_we_i;
	assign idx = wb_adr_i[7:2];
	assign cyc = (link_r == dp_buf_pkg::LINK_CYCLIC);
	assign wd_hit = cyc & exch_rx_i & ~kick_r & (count_r == dp_buf_pkg::COUNT_ONE);
	assign wipe = start_r | enter_await_i | drop_master_i | gc_wipe_i | wd_hit;
	assign rx_move   = out_rx_ok_i & ~out_hold_r & ~wipe;
	assign sync_move = (gc_sync_i | gc_unsync_i) & d_held_r & ~wipe & ~out_rx_ok_i;
	assign take_cmd  = rd & (idx == dp_buf_pkg::IDX_OUT_TAKE);
	assign send_move = in_send_req_i & ~in_hold_r & in_new_r;
	assign freeze_move = gc_freeze_i & freeze_en_r & in_new_r & ~in_send_req_i;
	assign pub_cmd   = rd & (idx == dp_buf_pkg::IDX_IN_PUB);
	assign swap_cmd  = rd & (idx == dp_buf_pkg::IDX_DIAG_SWAP);
	assign swap_now  = swap_cmd & (host_buf_r != dp_buf_pkg::PTR_NIL) & ~release_r;
	// bus-side move first, then the host command on its result
	always_comb begin
		out_bus = out_r;
		out_new_nxt = out_new_r;
		n_clr_nxt = n_clr_r;
		u_clr_nxt = u_clr_r;
		take_done = 1'b0;
		// wipe shifts the cleared D to N
		if (wipe | rx_move | sync_move) begin
			out_bus = push_n(out_r, 1'b0);
			out_new_nxt = 1'b1;
			n_clr_nxt = wipe;
		end
		out_nxt = out_bus;
		// take only when N is new
		if (take_cmd & out_new_nxt) begin
			out_nxt = pull_n(out_bus, 1'b1);
			u_clr_nxt = n_clr_nxt;
			out_new_nxt = 1'b0;
			take_done = 1'b1;
		end
	end

	always_comb begin
		in_bus = in_r;
		in_new_nxt = in_new_r;
		// fetch N before sending; skipped in hold mode
		if (send_move | freeze_move) begin
			in_bus = pull_n(in_r, 1'b0);
			in_new_nxt = 1'b0;
		end
		in_nxt = in_bus;
		if (pub_cmd) begin
			in_nxt = push_n(in_bus, 1'b1);
			in_new_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_r <= dp_buf_pkg::POS_RST;
			out_new_r <= 1'b0;
			n_clr_r <= 1'b0;
			u_clr_r <= 1'b0;
			in_r <= dp_buf_pkg::POS_RST;
			in_new_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
			out_new_r <= out_new_nxt;
			n_clr_r <= n_clr_nxt;
			u_clr_r <= u_clr_nxt;
			in_r <= in_nxt;
			in_new_r <= in_new_nxt;
		end
	end

	// output hold follows Sync/Unsync; d_held marks data parked in D
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_hold_r <= 1'b0;
			in_hold_r <= 1'b0;
			d_held_r <= 1'b0;
		end else begin
			out_hold_r <= (gc_sync_i & sync_en_r) | (out_hold_r & ~gc_unsync_i);
			in_hold_r <= (gc_freeze_i & freeze_en_r) | (in_hold_r & ~gc_unfreeze_i);
			d_held_r <= ~(wipe | sync_move) & (d_held_r | (out_rx_ok_i & out_hold_r));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			host_buf_r <= dp_buf_pkg::PTR_2;
			active_r <= dp_buf_pkg::PTR_1;
			release_r <= 1'b0;
			diag_swap_done_o <= 1'b0;
		end else begin
			diag_swap_done_o <= 1'b0;
			if (swap_now) begin
				active_r <= host_buf_r;
				// a buffer still on the wire is handed back only after it is sent
				if (diag_sending_i) begin
					host_buf_r <= dp_buf_pkg::PTR_NIL;
					release_r <= 1'b1;
				end else begin
					host_buf_r <= active_r;
					diag_swap_done_o <= 1'b1;
				end
			end else if (release_r & ~diag_sending_i) begin
				host_buf_r <= active_r ^ 2'h3;
				release_r <= 1'b0;
				diag_swap_done_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_r <= 1'b0;
		end else if (swap_now) begin
			// set wins over a fetch in the same cycle
			pend_r <= 1'b1;
		end else if (diag_fetched_i & ~diag_static_i) begin
			// static-diagnosis bit of byte 0 keeps it set
			pend_r <= 1'b0;
		end
	end

	// cyclic state only with all telegrams acknowledged
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_r <= dp_buf_pkg::LINK_AWAIT;
		end else begin
			case (link_r)
				dp_buf_pkg::LINK_AWAIT: begin
					if (go_cyclic_i & ~prm_cfg_pending_i & ~enter_await_i) begin
						link_r <= dp_buf_pkg::LINK_CYCLIC;
					end
				end
				dp_buf_pkg::LINK_CYCLIC: begin
					if (enter_await_i | wd_hit) begin
						link_r <= dp_buf_pkg::LINK_AWAIT;
					end
				end
				default: begin
					link_r <= dp_buf_pkg::LINK_AWAIT;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= dp_buf_pkg::COUNT_ZERO;
		end else if (cyc & exch_rx_i) begin
			if (kick_r) begin
				count_r <= reload_r;
			end else if (count_r != dp_buf_pkg::COUNT_ZERO) begin
				count_r <= count_r - dp_buf_pkg::COUNT_ONE;
			end
		end
	end

	// software registers; a kick written in the clearing cycle survives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			kick_r <= 1'b0;
			sync_en_r <= 1'b0;
			freeze_en_r <= 1'b0;
			reload_r <= dp_buf_pkg::RELOAD_RST;
		end else begin
			if (wr & (idx == dp_buf_pkg::IDX_CTRL) & wb_sel_i[0]) begin
				kick_r <= wb_dat_i[dp_buf_pkg::CTRL_KICK] | kick_r & ~(cyc & exch_rx_i);
				sync_en_r <= wb_dat_i[dp_buf_pkg::CTRL_SYNC_EN];
				freeze_en_r <= wb_dat_i[dp_buf_pkg::CTRL_FREEZE_EN];
			end else if (cyc & exch_rx_i) begin
				kick_r <= 1'b0;
			end
			if (wr & (idx == dp_buf_pkg::IDX_RELOAD)) begin
				if (wb_sel_i[0]) begin
					reload_r[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					reload_r[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		case (idx)
			dp_buf_pkg::IDX_CTRL: begin
				rdata[dp_buf_pkg::CTRL_KICK] = kick_r;
				rdata[dp_buf_pkg::CTRL_SYNC_EN] = sync_en_r;
				rdata[dp_buf_pkg::CTRL_FREEZE_EN] = freeze_en_r;
			end
			dp_buf_pkg::IDX_RELOAD: rdata[15:0] = reload_r;
			dp_buf_pkg::IDX_STATUS: begin
				rdata[dp_buf_pkg::ST_PENDING] = pend_r;
				rdata[dp_buf_pkg::ST_CYCLIC] = cyc;
				rdata[dp_buf_pkg::ST_OUT_HOLD] = out_hold_r;
				rdata[dp_buf_pkg::ST_IN_HOLD] = in_hold_r;
				rdata[31:16] = count_r;
			end
			dp_buf_pkg::IDX_IN_OWN: rdata[7:0] = in_r;
			dp_buf_pkg::IDX_IN_PUB: rdata[1:0] = in_nxt.n;
			dp_buf_pkg::IDX_OUT_OWN: rdata[7:0] = out_r;
			dp_buf_pkg::IDX_OUT_TAKE: begin
				rdata[dp_buf_pkg::TAKE_CLEARED] = u_clr_nxt;
				rdata[dp_buf_pkg::TAKE_NEW] = take_done;
				rdata[1:0] = out_nxt.u;
			end
			dp_buf_pkg::IDX_DIAG_OWN: begin
				// buffer 2 high, buffer 1 low
				rdata[3:2] = diag_code(dp_buf_pkg::PTR_2, host_buf_r, active_r, release_r,
					diag_sending_i);
				rdata[1:0] = diag_code(dp_buf_pkg::PTR_1, host_buf_r, active_r, release_r,
					diag_sending_i);
			end
			dp_buf_pkg::IDX_DIAG_SWAP: begin
				rdata[1:0] = swap_now ? (diag_sending_i ? dp_buf_pkg::PTR_NIL : active_r)
					: host_buf_r;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= rd ? rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_r <= 1'b1;
			output_received_irq_o <= 1'b0;
			diag_high_prio_o <= 1'b0;
			diag_send_buf_o <= dp_buf_pkg::PTR_1;
			dout_d_ptr_o <= dp_buf_pkg::PTR_1;
			din_d_ptr_o <= dp_buf_pkg::PTR_1;
			dout_wipe_o <= 1'b0;
			drop_master_o <= 1'b0;
			cyclic_exchange_state_o <= 1'b0;
		end else begin
			start_r <= 1'b0;
			output_received_irq_o <= rx_move | sync_move;
			diag_high_prio_o <= pend_r;
			diag_send_buf_o <= active_r;
			dout_d_ptr_o <= out_r.d;
			din_d_ptr_o <= in_r.d;
			dout_wipe_o <= wipe;
			drop_master_o <= wd_hit | drop_master_i;
			cyclic_exchange_state_o <= cyc;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_out_rx_irq: assert property (rx_move |=> output_received_irq_o &&
		(out_r.n == $past(out_r.d) || out_r.u == $past(out_r.d)))
		else $error("reception did not move D to N with interrupt");
	a_take_gated: assert property (take_cmd && !out_new_r && !(wipe | rx_move | sync_move)
		|=> out_r == $past(out_r))
		else $error("output take moved without a new N");
	a_wipe_clear: assert property (wipe |=> n_clr_r && (out_new_r || u_clr_r))
		else $error("wipe did not leave a cleared N");
	a_hold_keeps: assert property (out_hold_r && out_rx_ok_i && !wipe && !take_cmd
		|=> out_r == $past(out_r))
		else $error("hold mode moved output buffer");
	a_in_fetch: assert property (send_move && !pub_cmd |=> in_r.d == $past(in_r.n)
		&& in_r.n == dp_buf_pkg::PTR_NIL)
		else $error("input N not fetched before send");
	a_freeze_skip: assert property (in_hold_r && in_send_req_i && !pub_cmd && !gc_freeze_i
		|=> in_r == $past(in_r))
		else $error("hold mode moved input buffer");
	a_publish_ptr: assert property (pub_cmd |=> in_r.n != dp_buf_pkg::PTR_NIL
		&& wb_dat_o[1:0] == in_r.n)
		else $error("publish did not fill N");
	a_pend_set: assert property (swap_now |=> pend_r ##1 diag_high_prio_o)
		else $error("swap did not hold pending flag");
	a_pend_static: assert property (pend_r && diag_fetched_i && diag_static_i && !swap_now
		|=> pend_r)
		else $error("static diagnosis lost pending flag");
	a_cyclic_gate: assert property (!cyc && prm_cfg_pending_i |=> !cyc)
		else $error("cyclic state entered with pending telegrams");
	a_wd_expire: assert property (wd_hit |=> count_r == dp_buf_pkg::COUNT_ZERO && !cyc
		&& drop_master_o && dout_wipe_o)
		else $error("watchdog expiry not handled");
	a_kick_reload: assert property (cyc && exch_rx_i && kick_r && !wr
		|=> count_r == $past(reload_r) && !kick_r)
		else $error("kick did not reload counter");
	a_own_unique: assert property (out_r.d != out_r.n && out_r.u != out_r.n
		&& out_r.u != out_r.d && in_r.u != in_r.d)
		else $error("buffer held in two positions");
endmodule

// ==== dp_buf_pkg.sv ====
package dp_buf_pkg;
	localparam logic [1:0] PTR_NIL  = 2'h0;
	localparam logic [1:0] PTR_1    = 2'h1;
	localparam logic [1:0] PTR_2    = 2'h2;
	localparam logic [1:0] PTR_3    = 2'h3;
	localparam logic [1:0] OWN_NIL  = 2'h0;
	localparam logic [1:0] OWN_HOST = 2'h1;
	localparam logic [1:0] OWN_DEV  = 2'h2;
	localparam logic [1:0] OWN_SEND = 2'h3;
	// printed offsets are register indices; byte address is index times four
	localparam logic [5:0] IDX_CTRL      = 6'h01;
	localparam logic [5:0] IDX_RELOAD    = 6'h02;
	localparam logic [5:0] IDX_STATUS    = 6'h03;
	localparam logic [5:0] IDX_IN_OWN    = 6'h08;
	localparam logic [5:0] IDX_IN_PUB    = 6'h09;
	localparam logic [5:0] IDX_OUT_OWN   = 6'h0A;
	localparam logic [5:0] IDX_OUT_TAKE  = 6'h0B;
	localparam logic [5:0] IDX_DIAG_OWN  = 6'h0C;
	localparam logic [5:0] IDX_DIAG_SWAP = 6'h0D;
	localparam int CTRL_KICK      = 0;
	localparam int CTRL_SYNC_EN   = 1;
	localparam int CTRL_FREEZE_EN = 2;
	localparam int ST_PENDING     = 0;
	localparam int ST_CYCLIC      = 1;
	localparam int ST_OUT_HOLD    = 2;
	localparam int ST_IN_HOLD     = 3;
	localparam int ST_COUNT_LSB   = 16;
	localparam int TAKE_CLEARED   = 3;
	localparam int TAKE_NEW       = 2;
	localparam logic [15:0] RELOAD_RST  = 16'h0000;
	localparam logic [15:0] COUNT_ZERO  = 16'h0000;
	localparam logic [15:0] COUNT_ONE   = 16'h0001;

	// field order matches the ownership cells: F 7-6, U 5-4, N 3-2, D 1-0
	typedef struct packed {
		logic [1:0] f;
		logic [1:0] u;
		logic [1:0] n;
		logic [1:0] d;
	} buf_pos_t;

	localparam buf_pos_t POS_RST = '{f: PTR_3, u: PTR_2, n: PTR_NIL, d: PTR_1};

	typedef enum logic [1:0] {
		LINK_AWAIT  = 2'b01,
		LINK_CYCLIC = 2'b10
	} link_state_t;
endpackage

// ==== fieldbus_side_model.sv ====
module fieldbus_side_model (
	input  wire logic        clk_i,
	output logic      [11:0] ev_o,
	output logic             diag_static_o,
	output logic             diag_sending_o,
	output logic             prm_cfg_pending_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		ev_o = 12'h000;
		diag_static_o = 1'b0;
		diag_sending_o = 1'b0;
		prm_cfg_pending_o = 1'b0;
	end

	// one-cycle strobes
	// a strobe is high for exactly one edge so the device sees one event per call
	task automatic pulse(input int i);
		@(posedge clk_i);
		ev_o[i] <= 1'b1;
		@(posedge clk_i);
		ev_o[i] <= 1'b0;
	endtask

	// buffer lengths would count the internal bytes; no length crosses this edge
	// static flag mirrors bit 1 of byte 0 in the buffer being sent
	task automatic levels(input logic st, input logic snd, input logic pend);
		@(posedge clk_i);
		diag_static_o <= st;
		diag_sending_o <= snd;
		prm_cfg_pending_o <= pend;
	endtask
endmodule

// ==== tb_dp_slave_buffer_exchange.sv ====
module tb_dp_slave_buffer_exchange;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int E_RX = 0, E_SEND = 1, E_EXCH = 2, E_FETCH = 3, E_SYNC = 4, E_UNSYNC = 5;
	localparam int E_FRZ = 6, E_UNFRZ = 7, E_WIPE = 8, E_AWAIT = 9, E_DROP = 10, E_GO = 11;
	localparam logic [5:0] I_CTRL = dp_buf_pkg::IDX_CTRL, I_REL = dp_buf_pkg::IDX_RELOAD;
	localparam logic [5:0] I_ST = dp_buf_pkg::IDX_STATUS, I_INO = dp_buf_pkg::IDX_IN_OWN;
	localparam logic [5:0] I_PUB = dp_buf_pkg::IDX_IN_PUB, I_OUT = dp_buf_pkg::IDX_OUT_OWN;
	localparam logic [5:0] I_TAKE = dp_buf_pkg::IDX_OUT_TAKE, I_DIAG = dp_buf_pkg::IDX_DIAG_OWN;
	localparam logic [5:0] I_SWAP = dp_buf_pkg::IDX_DIAG_SWAP;

	logic        clk;
	logic        rst_r;
	logic        cyc_r;
	logic        stb_r;
	logic        we_r;
	logic [7:0]  adr_r;
	logic [31:0] dat_r;
	logic [3:0]  sel_r;
	logic [31:0] rdat;
	logic        ack;
	logic [11:0] ev;
	logic        st_lv;
	logic        snd_lv;
	logic        pend_lv;
	logic        irq;
	logic        swap_done;
	logic        prio;
	logic        wipe;
	logic        drop;
	logic        cyc_st;
	logic [1:0]  send_buf;
	logic [1:0]  dout_d;
	logic [1:0]  din_d;
	logic [31:0] q;
	logic [31:0] o1;
	int          mismatches;
	int          compares;
	int          n_irq;
	int          n_swap;
	int          n_wipe;
	int          n_drop;

	initial clk = 1'b0;
	always #5 clk = ~clk;

	dp_slave_buffer_exchange dp_slave_buffer_exchange_i (
		.clk_i(clk), .rst_i(rst_r), .wb_cyc_i(cyc_r), .wb_stb_i(stb_r), .wb_we_i(we_r),
		.wb_adr_i(adr_r), .wb_dat_i(dat_r), .wb_sel_i(sel_r), .wb_dat_o(rdat), .wb_ack_o(ack),
		.out_rx_ok_i(ev[E_RX]), .in_send_req_i(ev[E_SEND]), .exch_rx_i(ev[E_EXCH]),
		.diag_fetched_i(ev[E_FETCH]), .diag_static_i(st_lv), .diag_sending_i(snd_lv),
		.gc_sync_i(ev[E_SYNC]), .gc_unsync_i(ev[E_UNSYNC]), .gc_freeze_i(ev[E_FRZ]),
		.gc_unfreeze_i(ev[E_UNFRZ]), .gc_wipe_i(ev[E_WIPE]), .enter_await_i(ev[E_AWAIT]),
		.drop_master_i(ev[E_DROP]), .go_cyclic_i(ev[E_GO]), .prm_cfg_pending_i(pend_lv),
		.output_received_irq_o(irq), .diag_swap_done_o(swap_done), .diag_high_prio_o(prio),
		.diag_send_buf_o(send_buf), .dout_d_ptr_o(dout_d), .din_d_ptr_o(din_d),
		.dout_wipe_o(wipe), .drop_master_o(drop), .cyclic_exchange_state_o(cyc_st)
	);

	fieldbus_side_model fieldbus_side_model_i (
		.clk_i(clk), .ev_o(ev), .diag_static_o(st_lv), .diag_sending_o(snd_lv),
		.prm_cfg_pending_o(pend_lv)
	);

	// pulse outputs are counted so a missing or doubled pulse shows up
	always @(posedge clk) begin
		if (irq === 1'b1) n_irq++;
		if (swap_done === 1'b1) n_swap++;
		if (wipe === 1'b1) n_wipe++;
		if (drop === 1'b1) n_drop++;
	end

	task automatic summarize;
		if (mismatches == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// classic single cycle; the answer is waited for, never assumed
	task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge clk);
		cyc_r <= 1'b1;
		stb_r <= 1'b1;
		we_r <= we;
		adr_r <= {idx, 2'b00};
		dat_r <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = rdat;
		cyc_r <= 1'b0;
		stb_r <= 1'b0;
		we_r <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] idx, output logic [31:0] r);
		wb(1'b0, idx, 32'h0, r);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, idx, d, r);
	endtask

	task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, idx, 32'h0, r);
		check(r, exp);
	endtask

	task automatic fire(input int i);
		fieldbus_side_model_i.pulse(i);
		// pulse counters update one edge after the strobe ends; two more keep them settled
		repeat (3) @(posedge clk);
	endtask

	task automatic t_reset;
		// the host zeroes its U buffer here; this block tracks pointers only
		rdchk(I_INO, 32'hE1);
		rdchk(I_OUT, 32'h27);
		rdchk(I_DIAG, 32'h06);
		wr(I_INO, 32'h0);
		rdchk(I_INO, 32'hE1);
		rdchk(6'h0F, 32'h0);
		rdchk(I_ST, 32'h0);
		check(n_wipe, 32'h1);
	endtask

	task automatic t_output;
		rdchk(I_TAKE, 32'h0D);
		rdchk(I_OUT, 32'h93);
		rdchk(I_TAKE, 32'h09);
		fire(E_RX);
		rdchk(I_OUT, 32'h1E);
		fire(E_RX);
		check(n_irq, 32'h2);
		rdchk(I_OUT, 32'h1B);
		check({30'h0, dout_d}, 32'h3);
		rdchk(I_TAKE, 32'h06);
		rdchk(I_OUT, 32'h63);
	endtask

	task automatic t_sync;
		int k;
		wr(I_CTRL, 32'h2);
		fire(E_SYNC);
		rdchk(I_ST, 32'h4);
		k = n_irq;
		rd(I_OUT, o1);
		fire(E_RX);
		rdchk(I_OUT, o1);
		check(n_irq, k);
		fire(E_UNSYNC);
		rd(I_OUT, q);
		check({30'h0, q[3:2]}, {30'h0, o1[1:0]});
		check(n_irq, k + 1);
		rdchk(I_ST, 32'h0);
		wr(I_CTRL, 32'h0);
	endtask

	task automatic t_input;
		rdchk(I_PUB, 32'h02);
		rdchk(I_INO, 32'h39);
		fire(E_SEND);
		rdchk(I_INO, 32'h72);
		check({30'h0, din_d}, 32'h2);
		fire(E_SEND);
		rdchk(I_INO, 32'h72);
		wr(I_CTRL, 32'h4);
		fire(E_FRZ);
		rdchk(I_ST, 32'h8);
		rdchk(I_PUB, 32'h03);
		fire(E_SEND);
		rdchk(I_INO, 32'h1E);
		fire(E_UNFRZ);
		fire(E_SEND);
		rdchk(I_INO, 32'h93);
		rdchk(I_PUB, 32'h01);
		fire(E_FRZ);
		rdchk(I_INO, 32'hE1);
		check({30'h0, din_d}, 32'h1);
		fire(E_UNFRZ);
		wr(I_CTRL, 32'h0);
	endtask

	task automatic t_diag;
		rdchk(I_SWAP, 32'h01);
		rdchk(I_DIAG, 32'h09);
		check(n_swap, 32'h1);
		check({30'h0, send_buf}, 32'h2);
		rdchk(I_ST, 32'h1);
		check({31'h0, prio}, 32'h1);
		fieldbus_side_model_i.levels(1'b1, 1'b0, 1'b0);
		fire(E_FETCH);
		rdchk(I_ST, 32'h1);
		fieldbus_side_model_i.levels(1'b0, 1'b0, 1'b0);
		fire(E_FETCH);
		rdchk(I_ST, 32'h0);
		check({31'h0, prio}, 32'h0);
		fieldbus_side_model_i.levels(1'b0, 1'b1, 1'b0);
		rdchk(I_SWAP, 32'h00);
		rdchk(I_DIAG, 32'h0E);
		check(n_swap, 32'h1);
		fieldbus_side_model_i.levels(1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
		rdchk(I_DIAG, 32'h06);
		check(n_swap, 32'h2);
		check({30'h0, send_buf}, 32'h1);
	endtask

	task automatic t_watchdog;
		int k;
		int w;
		fieldbus_side_model_i.levels(1'b0, 1'b0, 1'b1);
		fire(E_GO);
		check({31'h0, cyc_st}, 32'h0);
		fieldbus_side_model_i.levels(1'b0, 1'b0, 1'b0);
		fire(E_GO);
		check({31'h0, cyc_st}, 32'h1);
		wr(I_REL, 32'h3);
		wr(I_CTRL, 32'h1);
		fire(E_EXCH);
		rd(I_ST, q);
		check({16'h0, q[31:16]}, 32'h3);
		rdchk(I_CTRL, 32'h0);
		k = n_drop;
		w = n_wipe;
		fire(E_EXCH);
		fire(E_EXCH);
		rd(I_ST, q);
		check({16'h0, q[31:16]}, 32'h1);
		check(n_drop, k);
		fire(E_EXCH);
		check(n_drop, k + 1);
		check({31'h0, cyc_st}, 32'h0);
		check(n_wipe, w + 1);
		rd(I_TAKE, q);
		check({30'h0, q[3:2]}, 32'h3);
	endtask

	task automatic t_wipe;
		int c[3];
		int w;
		int d;
		c = '{E_WIPE, E_AWAIT, E_DROP};
		d = n_drop;
		for (int i = 0; i < 3; i++) begin
			w = n_wipe;
			fire(c[i]);
			rd(I_TAKE, q);
			check({30'h0, q[3:2]}, 32'h3);
			check(n_wipe, w + 1);
		end
		check(n_drop, d + 1);
	endtask

	initial begin
		#50000;
		mismatches++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		summarize;
	end

	initial begin
		rst_r = 1'b1;
		cyc_r = 1'b0;
		stb_r = 1'b0;
		we_r = 1'b0;
		adr_r = 8'h00;
		dat_r = 32'h0;
		sel_r = 4'hF;
		mismatches = 0;
		compares = 0;
		n_irq = 0;
		n_swap = 0;
		n_wipe = 0;
		n_drop = 0;
		repeat (12) @(posedge clk);
		rst_r <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset;
		t_output;
		t_sync;
		t_input;
		t_diag;
		t_watchdog;
		t_wipe;
		summarize;
	end
endmodule
